//--- verilog/atrc_top.sv
// adc trigger selection, converter clock divider, flags, 16-bit access and result formatting
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps

module atrc_top #(
    parameter int EVENT_LINES = 8              // event routing network width
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [5:0]           reg_addr,     // register index
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,    // valid the cycle after reg_rd
    input  wire logic [EVENT_LINES-1:0] event_in,   // one-cycle event pulses, same clock
    input  wire logic [3:0]           vector_taken, // interrupt vector of channel n executed
    input  wire logic                 conv_done,    // pipeline reports one finished result
    input  wire logic [1:0]           conv_chan,    // channel of that result
    input  wire logic [11:0]          conv_data,    // raw result, two's complement when signed
    output logic [3:0]                conv_start,   // one-cycle start requests per channel
    output logic                      conv_flush,   // one-cycle pipeline flush
    output logic                      conv_clk_en,  // converter clock enable pulse
    output logic                      signed_mode,
    output logic [11:0]               trim_value,
    output logic [3:0]                channel_done_flag
);
    import atrc_pkg::*;

    initial begin
        if (EVENT_LINES != 8) $error("atrc_top: eight event lines expected");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register storage
    // every register is a byte on the plain port; wider values are split into
    // low and high bytes that pair through the shared access latch below
    // reserved bits are simply not stored, so they read back as zero
    logic [7:0]  ctrl_b_reg;          // signed_select, continuous_scan, result format
    logic [7:0]  event_trigger_control_reg;          // scan span, line select, event action
    logic [2:0]  clkdiv_reg;          // converter clock divider code
    logic [7:0]  latch_reg;           // shared high-byte latch
    logic [11:0] trim_reg;            // trim value
    logic [15:0] thr_reg;             // committed threshold
    logic [7:0]  cmode_reg;           // 2 bits of compare mode per channel
    logic [15:0] res_reg [CHANNELS];  // formatted results

    logic [1:0] scan_span;
    logic [2:0] line_sel;
    logic [2:0] event_action;
    logic       continuous_scan;
    logic [1:0] fmt;
    assign scan_span       = event_trigger_control_reg[7:6];
    assign line_sel        = event_trigger_control_reg[5:3];
    assign event_action    = event_trigger_control_reg[2:0];
    assign continuous_scan = ctrl_b_reg[POS_CONTIN];
    assign fmt             = ctrl_b_reg[POS_FMT +: 2];

    // decoded write strobes
    logic wr_thr_hi;
    logic wr_latch;
    assign wr_thr_hi = reg_wr && (reg_addr == OFF_THR_HI);
    assign wr_latch  = reg_wr && (reg_addr == OFF_LATCH);

    // plain configuration registers; reserved bits of control b are not stored
    // writes to unmapped indices fall through the default branch and are lost
    // the divider keeps only its three code bits, the upper five cannot be set
    // the trim high write stores its four bits directly, with no latch pairing,
    // because the pipeline only reads the trim as a whole level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_b_reg <= RST_BYTE;
            event_trigger_control_reg <= RST_BYTE;
            clkdiv_reg <= 3'b000;
            trim_reg   <= 12'h000;
            cmode_reg  <= RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_CTRL_B:  ctrl_b_reg <= reg_wdata & 8'h1E;
                OFF_EVENT_TRIGGER_CONTROL:  event_trigger_control_reg <= reg_wdata;
                OFF_CLKDIV:  clkdiv_reg <= reg_wdata[2:0];
                OFF_TRIM_LO: trim_reg[7:0] <= reg_wdata;
                OFF_TRIM_HI: trim_reg[11:8] <= reg_wdata[3:0];
                OFF_MODE:    cmode_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // 16-bit access: latch and threshold
    logic rd_low16;     // read of the low byte of a 16-bit register
    logic [7:0] hi_of_low;
    always_comb begin
        rd_low16  = 1'b0;
        hi_of_low = 8'h00;
        if (reg_addr == OFF_TRIM_LO) begin
            rd_low16  = 1'b1;
            hi_of_low = {4'h0, trim_reg[11:8]};
        end else if (reg_addr == OFF_THR_LO) begin
            rd_low16  = 1'b1;
            hi_of_low = thr_reg[15:8];
        end else if (reg_addr >= OFF_RES_BASE && reg_addr < OFF_MODE && !reg_addr[0]) begin
            rd_low16  = 1'b1;
            hi_of_low = res_reg[reg_addr[2:1]][15:8];
        end
    end

    // latch: direct writes, low-half writes of the threshold, low reads
    // priority: a direct write beats a threshold low write, which beats a read;
    // only one strobe stands in a cycle, so the order only matters for safety
    // limitation: any low-byte read overwrites a pending threshold low byte,
    // so software must not read a 16-bit register between the two writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= RST_BYTE;
        end else if (wr_latch) begin
            latch_reg <= reg_wdata;
        end else if (reg_wr && reg_addr == OFF_THR_LO) begin
            latch_reg <= reg_wdata;
        end else if (reg_rd && rd_low16) begin
            latch_reg <= hi_of_low;
        end
    end

    // threshold commits both bytes at once on the high write, so compares never tear
    // the trade-off is that a low write alone never changes the compare value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_reg <= 16'h0000;
        end else if (wr_thr_hi) begin
            thr_reg <= {reg_wdata, latch_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // converter clock divider; a flush restarts it
    // the enable pulse comes once every 2^(code+2) peripheral clocks
    // comparing with >= rather than == lets a code change to a faster rate
    // take effect at once instead of waiting for the counter to wrap
    logic [8:0] div_cnt;
    logic [8:0] div_max;
    logic       flush_now;
    // the shift amount is widened to four bits first: a three-bit sum would wrap
    // for codes 110 and 111 and give a far too fast converter clock
    logic [3:0] div_log2;
    assign div_log2 = 4'({1'b0, clkdiv_reg}) + 4'(DIV_BASE_LOG2);
    assign div_max  = 9'((10'd1 << div_log2) - 10'd1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt     <= 9'h000;
            conv_clk_en <= 1'b0;
        end else if (flush_now) begin
            div_cnt     <= 9'h000;
            conv_clk_en <= 1'b1;     // next peripheral edge is the next converter edge
        end else begin
            conv_clk_en <= (div_cnt >= div_max);
            div_cnt     <= (div_cnt >= div_max) ? 9'h000 : div_cnt + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event routing to channel starts
    // the selected window starts at line_sel; lines above the top line are absent,
    // which is why the upper selects offer fewer usable lines
    // a single scan and a resynchronised scan both listen to the lowest line only
    // continuous scanning adds a full span on every converter clock pulse,
    // except in the cycle of a resync, which already starts the span itself
    logic [7:0] ev_win;        // selected lines, lowest first
    logic [3:0] ev_avail;      // lines that exist from line_sel upward
    logic [3:0] span_mask;
    logic [3:0] start_next;
    logic       first_ev;
    always_comb begin
        ev_win    = 8'(event_in >> line_sel);
        ev_avail  = 4'((5'b10000 >> line_sel) - 5'b00001) | 4'(8'hF0 >> line_sel);
        ev_avail  = (line_sel <= 3'd4) ? 4'hF : 4'((5'h1 << (4'd8 - {1'b0, line_sel})) - 5'h1);
        span_mask = 4'((5'h2 << scan_span) - 5'h1);
        first_ev  = ev_win[0];
        start_next = 4'h0;
        flush_now  = 1'b0;
        case (event_action)
            3'b001, 3'b010, 3'b011, 3'b100: begin
                start_next = ev_win[3:0] & ev_avail
                           & 4'((5'h1 << event_action) - 5'h1);
            end
            ACT_SCAN: begin
                if (first_ev) start_next = span_mask;
            end
            ACT_RSCAN: begin
                if (first_ev) begin
                    start_next = span_mask;
                    flush_now  = 1'b1;
                end
            end
            default: ;                                              // none and reserved
        endcase
        if (continuous_scan && conv_clk_en && !flush_now) begin
            start_next = start_next | span_mask;
        end
    end

    // start and flush requests toward the pipeline
    // both are registered so the pipeline sees clean one-cycle pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start <= 4'h0;
            conv_flush <= 1'b0;
        end else begin
            conv_start <= start_next;
            conv_flush <= flush_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result formatting
    // the raw result is formatted as it arrives and stored already laid out,
    // so a read never depends on a format change made after the conversion
    // reserved format code 01 falls into the right-aligned twelve-bit layout
    logic        sgn;
    logic [15:0] fmt_res;
    assign sgn = ctrl_b_reg[POS_SIGNED];
    always_comb begin
        case (fmt)
            FMT_L12: fmt_res = {conv_data, 4'h0};
            FMT_R8:  fmt_res = {{8{sgn & conv_data[7]}}, conv_data[7:0]};
            default: fmt_res = {{4{sgn & conv_data[11]}}, conv_data};
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) res_reg[i] <= 16'h0000;
        end else if (conv_done) begin
            res_reg[conv_chan] <= fmt_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare against threshold and flags
    // the compare sees the formatted value, the same one software reads back
    // a seventeenth bit keeps unsigned values above the signed range positive
    logic signed [16:0] cmp_res;   // 17 bits so unsigned values compare as positive
    logic signed [16:0] cmp_thr;
    logic [1:0]         cm;
    logic               hit;
    logic [3:0]         flag_set;
    always_comb begin
        cmp_res = sgn ? {fmt_res[15], fmt_res} : {1'b0, fmt_res};
        cmp_thr = sgn ? {thr_reg[15], thr_reg} : {1'b0, thr_reg};
        cm      = cmode_reg[conv_chan*2 +: 2];
        case (cm)
            CMP_BELOW: hit = cmp_res < cmp_thr;
            CMP_ABOVE: hit = cmp_res > cmp_thr;
            default:   hit = 1'b1;
        endcase
        flag_set = (conv_done && hit) ? 4'(4'h1 << conv_chan) : 4'h0;
    end

    // set wins over both clears in the same cycle
    // so a result that lands while software clears the flag is never lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_done_flag <= 4'h0;
        end else begin
            channel_done_flag <= (channel_done_flag
                & ~vector_taken
                & ~((reg_wr && reg_addr == OFF_FLAGS) ? reg_wdata[3:0] : 4'h0))
                | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads give zero
    // outside a read cycle the data port returns to zero
    // high bytes of 16-bit registers always come from the latch,
    // which the preceding low-byte read has filled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OFF_CTRL_B:  reg_rdata <= ctrl_b_reg;
                OFF_EVENT_TRIGGER_CONTROL:  reg_rdata <= event_trigger_control_reg;
                OFF_CLKDIV:  reg_rdata <= {5'b00000, clkdiv_reg};
                OFF_FLAGS:   reg_rdata <= {4'h0, channel_done_flag};
                OFF_LATCH:   reg_rdata <= latch_reg;
                OFF_TRIM_LO: reg_rdata <= trim_reg[7:0];
                OFF_TRIM_HI: reg_rdata <= latch_reg;
                OFF_THR_LO:  reg_rdata <= thr_reg[7:0];
                OFF_THR_HI:  reg_rdata <= latch_reg;
                OFF_MODE:    reg_rdata <= cmode_reg;
                default: begin
                    if (reg_addr >= OFF_RES_BASE && reg_addr < OFF_MODE) begin
                        reg_rdata <= reg_addr[0] ? latch_reg
                                                 : res_reg[reg_addr[2:1]][7:0];
                    end else begin
                        reg_rdata <= 8'h00;
                    end
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // mirrors for the pipeline
    // registered copies keep every top-level output straight from a flip-flop;
    // they trail the register contents by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            signed_mode <= 1'b0;
            trim_value  <= 12'h000;
        end else begin
            signed_mode <= sgn;
            trim_value  <= trim_reg;
        end
    end
endmodule

//--- verilog/atrc_pkg.sv
// package: register map, field positions and constants for the adc trigger/result control
package atrc_pkg;
    // register byte offsets (register index on the plain port)
    localparam logic [5:0] OFF_CTRL_B     = 6'h01; // signed_select, continuous_scan, format
    localparam logic [5:0] OFF_EVENT_TRIGGER_CONTROL     = 6'h03; // event_trigger_control
    localparam logic [5:0] OFF_CLKDIV     = 6'h04; // converter_clock_divider
    localparam logic [5:0] OFF_FLAGS      = 6'h06; // channel_flags
    localparam logic [5:0] OFF_LATCH      = 6'h07; // access_high_byte_latch
    localparam logic [5:0] OFF_TRIM_LO    = 6'h0C; // trim_low
    localparam logic [5:0] OFF_TRIM_HI    = 6'h0D; // trim_high
    localparam logic [5:0] OFF_THR_LO     = 6'h18; // threshold_low
    localparam logic [5:0] OFF_THR_HI     = 6'h19; // threshold_high
    localparam logic [5:0] OFF_RES_BASE   = 6'h20; // channel n result low at base + 2n
    localparam logic [5:0] OFF_MODE       = 6'h28; // per-channel compare mode (own)
    // control register b field positions
    localparam int POS_SIGNED   = 4;
    localparam int POS_CONTIN   = 3;
    localparam int POS_FMT      = 1;
    // result format codes
    localparam logic [1:0] FMT_R12 = 2'b00;
    localparam logic [1:0] FMT_R8  = 2'b10;
    localparam logic [1:0] FMT_L12 = 2'b11;
    // event action codes
    localparam logic [2:0] ACT_NONE  = 3'b000;
    localparam logic [2:0] ACT_SCAN  = 3'b101;
    localparam logic [2:0] ACT_RSCAN = 3'b110;
    // compare modes per channel: 00 done, 01 below, 11 above
    localparam logic [1:0] CMP_BELOW = 2'b01;
    localparam logic [1:0] CMP_ABOVE = 2'b11;
    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    // divider base: code 000 divides by 4
    localparam int DIV_BASE_LOG2 = 2;
    localparam int CHANNELS = 4;
endpackage

//--- tb/atrc_chk_sva.sv
// checker: port-level assertions for the adc trigger/result control
`timescale 1ns/10ps
module atrc_chk
    import atrc_pkg::*;
#(
    parameter int EVENT_LINES = 8
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic [5:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire logic [EVENT_LINES-1:0] event_in,
    input wire logic [3:0]             vector_taken,
    input wire logic                   conv_done,
    input wire logic [3:0]             conv_start,
    input wire logic                   conv_flush,
    input wire logic                   conv_clk_en,
    input wire logic                   signed_mode,
    input wire logic [11:0]            trim_value,
    input wire logic [3:0]             channel_done_flag
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////////
// flags only ever rise from a finished result
AST_FLAG_SRC: assert property ((channel_done_flag & ~$past(channel_done_flag)) != 4'h0
    |-> $past(conv_done)) else $error("flag rose without a result");
// a taken vector clears its flag when no result competes
AST_VEC_CLR: assert property ((vector_taken != 4'h0 && !conv_done)
    |=> (channel_done_flag & $past(vector_taken)) == 4'h0) else $error("vector left flag set");
AST_W1C: assert property ((reg_wr && reg_addr == OFF_FLAGS && !conv_done)
    |=> (channel_done_flag & $past(reg_wdata[3:0])) == 4'h0) else $error("one did not clear");
AST_DIV_RSV: assert property ((reg_rd && reg_addr == OFF_CLKDIV)
    |=> reg_rdata[7:3] == 5'h00) else $error("divider upper bits not zero");
AST_FLAG_RD: assert property ((reg_rd && reg_addr == OFF_FLAGS)
    |=> reg_rdata == {4'h0, $past(channel_done_flag)}) else $error("flag read wrong");
// fastest divide is four, unless a resync restarts the divider
AST_DIV_GAP: assert property (conv_clk_en
    |=> (!conv_clk_en || conv_flush)[*3]) else $error("converter clock too fast");
AST_FLUSH: assert property (conv_flush |-> conv_clk_en && $past(event_in != '0))
    else $error("flush without event or clock restart");
AST_TRIM: assert property ((reg_wr && reg_addr == OFF_TRIM_LO)
    |-> ##2 trim_value[7:0] == $past(reg_wdata, 2)) else $error("trim low not stored");
AST_SIGNED: assert property ((reg_wr && reg_addr == OFF_CTRL_B)
    |-> ##2 signed_mode == $past(reg_wdata[POS_SIGNED], 2)) else $error("signed mode not stored");
AST_START: assert property (conv_start != 4'h0
    |-> $past(event_in != '0) || $past(conv_clk_en)) else $error("start without cause");
endmodule
bind atrc_top atrc_chk #(.EVENT_LINES(EVENT_LINES)) chk_u (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .event_in(event_in), .vector_taken(vector_taken),
    .conv_done(conv_done), .conv_start(conv_start), .conv_flush(conv_flush),
    .conv_clk_en(conv_clk_en), .signed_mode(signed_mode), .trim_value(trim_value),
    .channel_done_flag(channel_done_flag));

//--- tb/atrc_pipe_model.sv
// partner: behavioural converter pipeline answering start requests
`timescale 1ns/10ps
module atrc_pipe_model #(
    parameter int LAT = 3              // cycles between served results
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  conv_start,
    input  wire logic        conv_flush,
    input  wire logic [11:0] next_data, // value the next result carries
    output logic             conv_done,
    output logic [1:0]       conv_chan,
    output logic [11:0]      conv_data
);
logic [3:0] pend_reg;                  // channels waiting
int         busy_reg;
int         k;
// serves lowest pending channel; stale result lines toggle so nothing reads them late
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pend_reg <= 4'h0;
        busy_reg <= 0;
        conv_done <= 1'b0;
        conv_chan <= 2'h0;
        conv_data <= 12'h000;
    end else begin
        conv_done <= 1'b0;
        conv_chan <= ~conv_chan;
        conv_data <= ~conv_data;
        if (conv_flush) begin          // flush drops work in flight
            pend_reg <= conv_start;
            busy_reg <= LAT;
        end else if (busy_reg > 0) begin
            pend_reg <= pend_reg | conv_start;
            busy_reg <= busy_reg - 1;
        end else if (pend_reg != 4'h0) begin
            for (int i = 3; i >= 0; i--) if (pend_reg[i]) k = i;
            conv_done <= 1'b1;
            conv_chan <= k[1:0];
            conv_data <= next_data;
            pend_reg <= (pend_reg & ~(4'h1 << k)) | conv_start;
            busy_reg <= LAT;
        end else pend_reg <= conv_start;
    end
end
endmodule

//--- tb/test_adc_trigger_result_control.sv
// testbench: register, trigger, divider, flag and result format scenarios
`timescale 1ns/10ps
module test_adc_trigger_result_control;
import atrc_pkg::*;
logic clk = 0, rst_n = 0, reg_wr, reg_rd, conv_done, conv_flush, conv_clk_en, signed_mode;
logic [5:0] reg_addr;
logic [7:0] reg_wdata, reg_rdata, event_in;
logic [3:0] vector_taken, conv_start, channel_done_flag;
logic [1:0] conv_chan;
logic [11:0] conv_data, trim_value, next_data;
int fail_count = 0, checks_done = 0, n;
always #2.5 clk = ~clk;
atrc_top #(.EVENT_LINES(8)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_in(event_in), .vector_taken(vector_taken), .conv_done(conv_done),
    .conv_chan(conv_chan), .conv_data(conv_data), .conv_start(conv_start),
    .conv_flush(conv_flush), .conv_clk_en(conv_clk_en), .signed_mode(signed_mode),
    .trim_value(trim_value), .channel_done_flag(channel_done_flag));
atrc_pipe_model #(.LAT(3)) pipe_u (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
    .conv_flush(conv_flush), .next_data(next_data), .conv_done(conv_done),
    .conv_chan(conv_chan), .conv_data(conv_data));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
        fail_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task close_out;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
// bus cycles: one gap cycle so no strobe is driven twice in one step
task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0; @(posedge clk);
endtask
task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
    @(posedge clk);
endtask
// one-cycle event, then starts and flush are looked at in the answer cycle
task automatic pulse(input logic [7:0] v, input logic [3:0] st, input logic fl);
    event_in <= v; @(posedge clk); event_in <= 8'h00;
    #1 chk({11'h0, conv_flush, conv_start}, {11'h0, fl, st});
    @(posedge clk);
endtask
// counts edges to the next converter clock pulse; returns just after it
task automatic wait_en(output int c);
    c = 0;
    do begin @(posedge clk); #1 c++; end while (!conv_clk_en && c < 1100);
    if (c >= 1100) begin chk(16'h1, 16'h0); close_out; end
endtask
////////////////////////////////////////////////////////////////////////////////
task t_regs;
    wr(OFF_CLKDIV, 8'hFF); rdchk(OFF_CLKDIV, 8'h07);
    wr(OFF_CLKDIV, 8'h00); rdchk(OFF_FLAGS, 8'h00);
    rdchk(6'h3F, 8'h00);
    wr(OFF_LATCH, 8'hA5); rdchk(OFF_LATCH, 8'hA5);
    wr(OFF_TRIM_LO, 8'h34); wr(OFF_TRIM_HI, 8'hF2);
    #1 chk({4'h0, trim_value}, 16'h0234);
    $display("t_regs done");
endtask
task t_div;
    for (int c = 0; c < 8; c++) begin
        wr(OFF_CLKDIV, 8'(c)); wait_en(n); wait_en(n);
        chk(16'(n), 16'(4 << c));
        @(posedge clk);
    end
    wr(OFF_CLKDIV, 8'h00);
    $display("t_div done");
endtask
task t_ev;
    for (int s = 0; s < 8; s++) for (int a = 0; a < 8; a++) if (a < 5 || a == 7) begin
        wr(OFF_EVENT_TRIGGER_CONTROL, {2'b00, 3'(s), 3'(a)});
        n = (a == 7) ? 0 : ((a < 8 - s) ? a : 8 - s);
        pulse(8'hFF, 4'((1 << n) - 1), 1'b0);
        if (a == 4 && s < 7) pulse(8'(1 << (s + 1)), 4'h2, 1'b0);
    end
    $display("t_ev done");
endtask
task t_scan;
    for (int sp = 0; sp < 4; sp++) for (int a = 5; a < 7; a++) begin
        wr(OFF_EVENT_TRIGGER_CONTROL, {2'(sp), 3'd2, 3'(a)});
        pulse(8'h08, 4'h0, 1'b0);
        pulse(8'h04, 4'((2 << sp) - 1), a == 6);
    end
    $display("t_scan done");
endtask
task t_flags;
    repeat (30) @(posedge clk);
    wr(OFF_FLAGS, 8'h0F); wr(OFF_EVENT_TRIGGER_CONTROL, 8'h04); next_data <= 12'h123;
    pulse(8'h0F, 4'hF, 1'b0);
    repeat (20) @(posedge clk);
    rdchk(OFF_FLAGS, 8'h0F);
    wr(OFF_FLAGS, 8'h05); rdchk(OFF_FLAGS, 8'h0A);
    vector_taken <= 4'h8; @(posedge clk); vector_taken <= 4'h0; @(posedge clk);
    rdchk(OFF_FLAGS, 8'h02);
    $display("t_flags done");
endtask
// rows: format, signed, high byte, low byte for raw 0x9A5
logic [18:0] fmt_tab [5] = '{{FMT_R12, 1'b0, 16'h09A5}, {FMT_R12, 1'b1, 16'hF9A5},
    {FMT_R8, 1'b0, 16'h00A5}, {FMT_R8, 1'b1, 16'hFFA5}, {FMT_L12, 1'b0, 16'h9A50}};
task t_fmt;
    wr(OFF_EVENT_TRIGGER_CONTROL, 8'h01); next_data <= 12'h9A5;
    foreach (fmt_tab[i]) begin
        wr(OFF_CTRL_B, {3'b000, fmt_tab[i][16], 1'b0, fmt_tab[i][18:17], 1'b0});
        #1 chk({15'h0, signed_mode}, {15'h0, fmt_tab[i][16]});
        wr(OFF_FLAGS, 8'h0F); pulse(8'h01, 4'h1, 1'b0);
        repeat (10) @(posedge clk);
        rdchk(OFF_RES_BASE, fmt_tab[i][7:0]);
        rdchk(OFF_LATCH, fmt_tab[i][15:8]);
        rdchk(OFF_RES_BASE + 6'h01, fmt_tab[i][15:8]);
    end
    $display("t_fmt done");
endtask
// minus sixteen signed is below five; as unsigned it is far above
task t_thr;
    wr(OFF_THR_LO, 8'hF0); rdchk(OFF_LATCH, 8'hF0);
    wr(OFF_THR_HI, 8'hFF); rdchk(OFF_THR_LO, 8'hF0); rdchk(OFF_THR_HI, 8'hFF);
    wr(OFF_MODE, 8'h03); next_data <= 12'h005;
    for (int sg = 0; sg < 2; sg++) begin
        wr(OFF_CTRL_B, {3'b000, 1'(sg), 4'h0}); wr(OFF_FLAGS, 8'h0F);
        pulse(8'h01, 4'h1, 1'b0);
        repeat (10) @(posedge clk);
        rdchk(OFF_FLAGS, 8'(sg));
    end
    wr(OFF_MODE, 8'h00);
    $display("t_thr done");
endtask
task t_cont;
    wr(OFF_EVENT_TRIGGER_CONTROL, 8'h40); wr(OFF_CTRL_B, 8'h08);
    wait_en(n); @(posedge clk);
    #1 chk({12'h0, conv_start}, 16'h0003);
    @(posedge clk); wr(OFF_CTRL_B, 8'h00);
    $display("t_cont done");
endtask
initial begin
    reg_addr = 6'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    event_in = 8'h00; vector_taken = 4'h0; next_data = 12'h000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs; t_div; t_ev; t_scan; t_flags; t_fmt; t_thr; t_cont;
    close_out;
end
endmodule
